// ==== bench/icp_regs_bench.sv ====
// Self-checking bench for the interrupt register block
`timescale 1ns/1ps
module icp_regs_bench;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [15:0] evt_group0;
  logic [15:0] evt_group1;
  logic [15:0] evt_group4;
  logic        core_req;
  logic        irq;
  logic [2:0]  core_level;
  logic [5:0]  core_src;
  logic        clk_en = 1'b1;
  logic        fire_go = 1'b0;
  logic [1:0]  fire_grp = 2'h0;
  logic [15:0] fire_msk = 16'h0000;
  logic [31:0] rd;
  logic        err;
  int          miscompares = 0;
  int          n_checks = 0;
  localparam logic [7:0]  ADR [8] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C};
  localparam logic [15:0] RSTV [8] = '{0, 0, 0, 0, 0, 0, 16'h4444, 16'h4440};
  localparam logic [15:0] IMPL [8] = '{16'h3FEF, 16'h20DB, 16'h0002, 16'h3FEF,
                                       16'h20DB, 16'h0002, 16'h7777, 16'h7770};

  always #50 pclk = ~pclk;

  icp_regs dut (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .evt_group0, .evt_group1, .evt_group4,
    .core_req, .core_level, .core_src, .irq);
  icp_src_model src (.pclk, .presetn, .fire_go, .fire_grp, .fire_msk, .evt_group0,
    .evt_group1, .evt_group4);

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      miscompares++;
    end
  endtask

  // Ends one edge after release so the next setup never lands in the same step
  // A slave that never answers is caught by the watchdog, not here
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(nm, exp, rd);
  endtask

  task automatic fire(input logic [1:0] g, input logic [15:0] m);
    fire_grp <= g;
    fire_msk <= m;
    fire_go  <= 1'b1;
    @(posedge pclk);
    fire_go  <= 1'b0;
    repeat (4) @(posedge pclk);
  endtask

  // ****************************************************************
  // Sequence
  // ****************************************************************
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    foreach (ADR[i]) begin
      rdc("reset", ADR[i], {16'h0000, RSTV[i]});
      apb(1'b1, ADR[i], 32'hFFFF_FFFF);
      rdc("ones", ADR[i], {16'h0000, IMPL[i]});
    end
    foreach (ADR[i]) begin
      apb(1'b1, ADR[i], 32'h0000_0000);
      rdc("zero", ADR[i], 32'h0000_0000);
    end
    apb(1'b0, 8'h20, 32'h0000_0000);
    apb(1'b0, 8'h2C, 32'h0000_0000);
    chk("slverr", 32'h0000_0001, {31'h0, err});
    chk("unmapped", 32'h0000_0000, rd);
    apb(1'b1, 8'h14, 32'h0000_0002);
    apb(1'b1, 8'h18, 32'h0000_4444);
    apb(1'b1, 8'h1C, 32'h0000_4440);
    apb(1'b1, 8'h24, 32'h0000_0003);
    fire(2'h2, 16'h0002);
    rdc("flag4", 8'h08, 32'h0000_0002);
    chk("core", {22'h0, 1'b1, 3'h4, 6'h21}, {22'h0, core_req, core_level, core_src});
    chk("irq", 32'h0000_0001, {31'h0, irq});
    rdc("core_reg", 8'h28, 32'h0000_0219);
    rdc("status", 8'h20, 32'h0000_0003);
    repeat (2) @(posedge pclk);
    chk("irq_clear", 32'h0000_0000, {31'h0, irq});
    apb(1'b1, 8'h08, 32'h0000_0000);
    apb(1'b1, 8'h14, 32'h0000_0000);
    fire(2'h2, 16'h0002);
    rdc("flag4_gated", 8'h08, 32'h0000_0002);
    chk("gated", 32'h0000_0000, {31'h0, core_req});
    apb(1'b1, 8'h18, 32'h0000_0172);
    apb(1'b1, 8'h0C, 32'h0000_000F);
    fire(2'h0, 16'h000F);
    rdc("flag0", 8'h00, 32'h0000_000F);
    chk("top7", {22'h0, 1'b1, 3'h7, 6'h01}, {22'h0, core_req, core_level, core_src});
    apb(1'b1, 8'h18, 32'h0000_0102);
    // Core outputs follow a level write one edge after it lands
    @(posedge pclk);
    chk("top2", {22'h0, 1'b1, 3'h2, 6'h00}, {22'h0, core_req, core_level, core_src});
    apb(1'b1, 8'h18, 32'h0000_0000);
    @(posedge pclk);
    chk("all_off", 32'h0000_0000, {31'h0, core_req});
    // An event while the clock enable is low must leave no trace
    clk_en <= 1'b0;
    fire(2'h1, 16'h0001);
    clk_en <= 1'b1;
    rdc("frozen", 8'h04, 32'h0000_0000);
    report_and_stop();
  end

  // Far above the few hundred cycles the sequence needs
  initial begin
    repeat (5000) @(posedge pclk);
    miscompares++;
    report_and_stop();
  end
endmodule // icp_regs_bench

// ==== bench/icp_regs_props.sv ====
// Port checker for the interrupt register block
`timescale 1ns/1ps
module icp_regs_props (
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        clk_en,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Events and core
  input wire logic [15:0] evt_group0,
  input wire logic [15:0] evt_group1,
  input wire logic [15:0] evt_group4,
  input wire logic        core_req,
  input wire logic [2:0]  core_level,
  input wire logic [5:0]  core_src,
  input wire logic        irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic rd_done = psel && penable && pready && !pwrite;

  ans_next_a: assert property (psel && !penable && !pready && clk_en |=> pready)
    else $error("no access answer");
  ans_once_a: assert property (pready |=> !pready)
    else $error("answer too long");
  ans_cause_a: assert property (pready |-> $past(psel) && !$past(penable))
    else $error("answer without setup");
  hi_zero_a: assert property (rd_done |-> prdata[31:16] == 16'h0000)
    else $error("upper half not zero");
  flag4_a: assert property (rd_done && paddr == 8'h08 |-> (prdata & ~32'h0002) == 0)
    else $error("flags4 extra bits");
  gate0_a: assert property (rd_done && paddr == 8'h0C |-> (prdata & ~32'h3FEF) == 0)
    else $error("gate0 extra bits");
  gate1_a: assert property (rd_done && paddr == 8'h10 |-> (prdata & ~32'h20DB) == 0)
    else $error("gate1 extra bits");
  gate4_a: assert property (rd_done && paddr == 8'h14 |-> (prdata & ~32'h0002) == 0)
    else $error("gate4 extra bits");
  level0_a: assert property (rd_done && paddr == 8'h18 |-> (prdata & ~32'h7777) == 0)
    else $error("level0 extra bits");
  level1_a: assert property (rd_done && paddr == 8'h1C |-> (prdata & ~32'h7770) == 0)
    else $error("level1 extra bits");
  idle_level_a: assert property (!core_req |-> core_level == 3'h0)
    else $error("level without request");
  req_level_a: assert property (core_req |-> core_level != 3'h0 && core_src < 6'h30)
    else $error("request at level zero");
endmodule // icp_regs_props

bind icp_regs icp_regs_props u_props (.pclk, .presetn, .clk_en, .psel, .penable,
  .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .evt_group0, .evt_group1,
  .evt_group4, .core_req, .core_level, .core_src, .irq);

// ==== bench/icp_src_model.sv ====
// Peripheral event sources that pulse on command
`timescale 1ns/1ps
module icp_src_model (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Command
  input  wire logic        fire_go,
  input  wire logic [1:0]  fire_grp,
  input  wire logic [15:0] fire_msk,
  // Event pulses
  output logic      [15:0] evt_group0,
  output logic      [15:0] evt_group1,
  output logic      [15:0] evt_group4
);
  // One-cycle pulses, so a later software clear is not undone by a stuck event
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt_group0 <= 16'h0000;
      evt_group1 <= 16'h0000;
      evt_group4 <= 16'h0000;
    end else begin
      evt_group0 <= (fire_go && fire_grp == 2'h0) ? fire_msk : 16'h0000;
      evt_group1 <= (fire_go && fire_grp == 2'h1) ? fire_msk : 16'h0000;
      evt_group4 <= (fire_go && fire_grp == 2'h2) ? fire_msk : 16'h0000;
    end
  end
endmodule // icp_src_model

// ==== include/icp_pkg.sv ====
// Constants shared by the interrupt enable and priority register block
package icp_pkg;

  // ****************************************************************
  // Bus and register geometry
  // ****************************************************************
  localparam int          ADDR_W  = 8;
  localparam int          DATA_W  = 32;
  localparam int          REG_W   = 16;
  localparam int          LVL_W   = 3;
  localparam int          GRP_W   = 16;
  localparam int          NUM_SRC = 48;
  localparam int          SRC_W   = 6;
  localparam int          IRQ_W   = 2;

  // ****************************************************************
  // Register byte offsets
  // ****************************************************************
  localparam logic [7:0]  OFF_FLAGS0 = 8'h00;
  localparam logic [7:0]  OFF_FLAGS1 = 8'h04;
  localparam logic [7:0]  OFF_FLAGS4 = 8'h08;
  localparam logic [7:0]  OFF_GATE0  = 8'h0C;
  localparam logic [7:0]  OFF_GATE1  = 8'h10;
  localparam logic [7:0]  OFF_GATE4  = 8'h14;
  localparam logic [7:0]  OFF_LEVEL0 = 8'h18;
  localparam logic [7:0]  OFF_LEVEL1 = 8'h1C;
  localparam logic [7:0]  OFF_IRQ_ST = 8'h20;
  localparam logic [7:0]  OFF_IRQ_MK = 8'h24;
  localparam logic [7:0]  OFF_CORE   = 8'h28;

  // ****************************************************************
  // Implemented-bit masks and reset values
  // ****************************************************************
  localparam logic [15:0] IMPL_GRP0   = 16'h3FEF;
  localparam logic [15:0] IMPL_GRP1   = 16'h20DB;
  localparam logic [15:0] IMPL_GRP4   = 16'h0002;
  localparam logic [15:0] IMPL_LEVEL0 = 16'h7777;
  localparam logic [15:0] IMPL_LEVEL1 = 16'h7770;
  localparam logic [15:0] RST_FLAGS   = 16'h0000;
  localparam logic [15:0] RST_LEVEL0  = 16'h4444;
  localparam logic [15:0] RST_LEVEL1  = 16'h4440;
  localparam logic [1:0]  IMPL_IRQ    = 2'h3;
  localparam logic [1:0]  RST_IRQ     = 2'h0;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int          UART_ERR_BIT = 1;
  localparam int          FLD_HI       = 12;
  localparam int          FLD_MID      = 8;
  localparam int          FLD_LO       = 4;
  localparam int          FLD_BASE     = 0;
  localparam int          SRC_TIMER1   = 3;
  localparam int          SRC_CMP1     = 2;
  localparam int          SRC_CAP1     = 1;
  localparam int          SRC_EXT0     = 0;
  localparam int          SRC_TIMER2   = 7;
  localparam int          SRC_CMP2     = 6;
  localparam int          SRC_CAP2     = 5;
  localparam int          GRP1_BASE    = 16;
  localparam int          GRP4_BASE    = 32;
  localparam int          IRQ_FLAG_EVT = 0;
  localparam int          IRQ_REQ_EVT  = 1;
  localparam logic [2:0]  LEVEL_OFF    = 3'h0;
  localparam logic [2:0]  LEVEL_FIXED  = 3'h4;

endpackage

// ==== src/icp_bit_reg.sv ====
// Software register with per-bit hardware set, clear and implemented mask
`timescale 1ns/1ps
module icp_bit_reg #(
  parameter int          W    = 16,
  parameter logic [W-1:0] IMPL = '1,
  parameter logic [W-1:0] RST  = '0
) (
  // Clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         clk_en,
  // Software write
  input  wire logic         wr_en,
  input  wire logic [W-1:0] wdata,
  // Hardware set and clear
  input  wire logic [W-1:0] set,
  input  wire logic [W-1:0] clr,
  // Held value
  output logic      [W-1:0] q
);

  logic [W-1:0] q_d;

  // Set is applied last so an event in the clearing cycle survives
  assign q_d = (((wr_en ? wdata : q) & ~clr) | set) & IMPL; // R3

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= RST & IMPL; // R2
    end else if (clk_en) begin
      q <= q_d;
    end
  end

endmodule // icp_bit_reg

// ==== src/icp_level_arb.sv ====
// Picks the highest-level live request among all sources
`timescale 1ns/1ps
module icp_level_arb #(
  parameter int N     = 48,
  parameter int LW    = 3,
  parameter int IDW   = 6
) (
  // Candidate sources
  input  wire logic [N-1:0]    req,
  input  wire logic [N*LW-1:0] lvl,
  // Winner
  output logic                 win_valid,
  output logic      [LW-1:0]   win_level,
  output logic      [IDW-1:0]  win_id
);

  // Ties go to the lowest source number, a fixed natural order
  always_comb begin
    win_valid = 1'b0;
    win_level = '0;
    win_id    = '0;
    for (int i = 0; i < N; i++) begin
      if (req[i] && (lvl[i*LW +: LW] > win_level)) begin // R14
        win_valid = 1'b1;
        win_level = lvl[i*LW +: LW];
        win_id    = IDW'(i);
      end
    end
  end

endmodule // icp_level_arb

// ==== src/icp_regs.sv ====
// Interrupt flag, enable and priority registers with APB access
// What this block does
// R1 - UART error flag bit 1 records request
// R2 - Flags and enables readable, writable, reset zero
// R3 - Unimplemented bits read zero, ignore writes
// R4 - Enable bit gates its source's request
// R5 - Enable register 0 bit map
// R6 - Enable register 1 bit map
// R7 - Enable register 4 only bit 1
// R8 - Level fields binary, one to seven
// R9 - Level zero disables the source
// R10 - Level fields reset to four
// R11 - Level register 0 field map
// R12 - Level register 1 field map
// R13 - Flag register 0 matches enable layout
// R14 - Request highest nonzero enabled flagged level
//
// Design decisions made here: the register addresses and the APB register port.
`timescale 1ns/1ps
module icp_regs (
  // Clock, reset, enable
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clk_en,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Peripheral event pulses, one bit per source
  input  wire logic [15:0] evt_group0,
  input  wire logic [15:0] evt_group1,
  input  wire logic [15:0] evt_group4,
  // Request to the core
  output logic             core_req,
  output logic      [2:0]  core_level,
  output logic      [5:0]  core_src,
  // Interrupt line
  output logic             irq
);

  // ****************************************************************
  // APB decode
  // ****************************************************************
  logic        pready_q;
  logic        pslverr_q;
  logic [31:0] prdata_q;
  logic        setup;
  logic        done;
  logic        wr_done;
  logic        rd_done;
  logic        sel_flags0;
  logic        sel_flags1;
  logic        sel_flags4;
  logic        sel_gate0;
  logic        sel_gate1;
  logic        sel_gate4;
  logic        sel_level0;
  logic        sel_level1;
  logic        sel_irq_st;
  logic        sel_irq_mk;
  logic        sel_core;
  logic        mapped;

  // No wait states: answer is prepared at setup, given in the first access cycle
  assign setup   = psel & ~penable & ~pready_q;
  assign done    = psel & penable & pready_q;
  assign wr_done = done & pwrite & ~pslverr_q;
  assign rd_done = done & ~pwrite & ~pslverr_q;

  assign sel_flags0 = (paddr == icp_pkg::OFF_FLAGS0);
  assign sel_flags1 = (paddr == icp_pkg::OFF_FLAGS1);
  assign sel_flags4 = (paddr == icp_pkg::OFF_FLAGS4);
  assign sel_gate0  = (paddr == icp_pkg::OFF_GATE0);
  assign sel_gate1  = (paddr == icp_pkg::OFF_GATE1);
  assign sel_gate4  = (paddr == icp_pkg::OFF_GATE4);
  assign sel_level0 = (paddr == icp_pkg::OFF_LEVEL0);
  assign sel_level1 = (paddr == icp_pkg::OFF_LEVEL1);
  assign sel_irq_st = (paddr == icp_pkg::OFF_IRQ_ST);
  assign sel_irq_mk = (paddr == icp_pkg::OFF_IRQ_MK);
  assign sel_core   = (paddr == icp_pkg::OFF_CORE);
  assign mapped     = sel_flags0 | sel_flags1 | sel_flags4 | sel_gate0 | sel_gate1
                    | sel_gate4 | sel_level0 | sel_level1 | sel_irq_st | sel_irq_mk
                    | sel_core;

  // ****************************************************************
  // Register storage
  // ****************************************************************
  logic [15:0] flags0;
  logic [15:0] flags1;
  logic [15:0] flags4;
  logic [15:0] gate0;
  logic [15:0] gate1;
  logic [15:0] gate4;
  logic [15:0] level0;
  logic [15:0] level1;
  logic [1:0]  irq_st;
  logic [1:0]  irq_mk;
  logic [1:0]  irq_set;
  logic [1:0]  irq_clr;
  logic [15:0] wr_lo;
  logic [15:0] no_bits;

  assign wr_lo   = pwdata[15:0];
  assign no_bits = '0;

  // Source events set their pending flag; software may also set or clear
  icp_bit_reg #(.W(16), .IMPL(icp_pkg::IMPL_GRP0), .RST(icp_pkg::RST_FLAGS)) u_flags0 (
    .pclk    (pclk),
    .presetn (presetn),
    .clk_en  (clk_en),
    .wr_en   (wr_done & sel_flags0),
    .wdata   (wr_lo),
    .set     (evt_group0), // R13
    .clr     (no_bits),
    .q       (flags0)
  );

  icp_bit_reg #(.W(16), .IMPL(icp_pkg::IMPL_GRP1), .RST(icp_pkg::RST_FLAGS)) u_flags1 (
    .pclk    (pclk),
    .presetn (presetn),
    .clk_en  (clk_en),
    .wr_en   (wr_done & sel_flags1),
    .wdata   (wr_lo),
    .set     (evt_group1),
    .clr     (no_bits),
    .q       (flags1)
  );

  icp_bit_reg #(.W(16), .IMPL(icp_pkg::IMPL_GRP4), .RST(icp_pkg::RST_FLAGS)) u_flags4 (
    .pclk    (pclk),
    .presetn (presetn),
    .clk_en  (clk_en),
    .wr_en   (wr_done & sel_flags4),
    .wdata   (wr_lo),
    .set     (evt_group4), // R1
    .clr     (no_bits),
    .q       (flags4)
  );

  icp_bit_reg #(.W(16), .IMPL(icp_pkg::IMPL_GRP0), .RST(icp_pkg::RST_FLAGS)) u_gate0 (
    .pclk    (pclk),
    .presetn (presetn),
    .clk_en  (clk_en),
    .wr_en   (wr_done & sel_gate0), // R5
    .wdata   (wr_lo),
    .set     (no_bits),
    .clr     (no_bits),
    .q       (gate0)
  );

  icp_bit_reg #(.W(16), .IMPL(icp_pkg::IMPL_GRP1), .RST(icp_pkg::RST_FLAGS)) u_gate1 (
    .pclk    (pclk),
    .presetn (presetn),
    .clk_en  (clk_en),
    .wr_en   (wr_done & sel_gate1), // R6
    .wdata   (wr_lo),
    .set     (no_bits),
    .clr     (no_bits),
    .q       (gate1)
  );

  icp_bit_reg #(.W(16), .IMPL(icp_pkg::IMPL_GRP4), .RST(icp_pkg::RST_FLAGS)) u_gate4 (
    .pclk    (pclk),
    .presetn (presetn),
    .clk_en  (clk_en),
    .wr_en   (wr_done & sel_gate4), // R7
    .wdata   (wr_lo),
    .set     (no_bits),
    .clr     (no_bits),
    .q       (gate4)
  );

  icp_bit_reg #(.W(16), .IMPL(icp_pkg::IMPL_LEVEL0), .RST(icp_pkg::RST_LEVEL0)) u_level0 (
    .pclk    (pclk),
    .presetn (presetn),
    .clk_en  (clk_en),
    .wr_en   (wr_done & sel_level0), // R11
    .wdata   (wr_lo),
    .set     (no_bits),
    .clr     (no_bits),
    .q       (level0) // R10
  );

  icp_bit_reg #(.W(16), .IMPL(icp_pkg::IMPL_LEVEL1), .RST(icp_pkg::RST_LEVEL1)) u_level1 (
    .pclk    (pclk),
    .presetn (presetn),
    .clk_en  (clk_en),
    .wr_en   (wr_done & sel_level1), // R12
    .wdata   (wr_lo),
    .set     (no_bits),
    .clr     (no_bits),
    .q       (level1) // R10
  );

  // Read clears only the bits that were returned, so a late event stays
  assign irq_clr = (rd_done & sel_irq_st) ? prdata_q[1:0] : 2'h0;

  icp_bit_reg #(.W(2), .IMPL(icp_pkg::IMPL_IRQ), .RST(icp_pkg::RST_IRQ)) u_irq_st (
    .pclk    (pclk),
    .presetn (presetn),
    .clk_en  (clk_en),
    .wr_en   (1'b0),
    .wdata   (2'h0),
    .set     (irq_set),
    .clr     (irq_clr),
    .q       (irq_st)
  );

  icp_bit_reg #(.W(2), .IMPL(icp_pkg::IMPL_IRQ), .RST(icp_pkg::RST_IRQ)) u_irq_mk (
    .pclk    (pclk),
    .presetn (presetn),
    .clk_en  (clk_en),
    .wr_en   (wr_done & sel_irq_mk),
    .wdata   (pwdata[1:0]),
    .set     (2'h0),
    .clr     (2'h0),
    .q       (irq_mk)
  );

  // ****************************************************************
  // Source levels and arbitration
  // ****************************************************************
  logic [47:0]  live;
  logic [143:0] lvl;
  logic         win_valid;
  logic [2:0]   win_level;
  logic [5:0]   win_id;

  // Flag and enable both required; level zero never wins the compare
  assign live = {flags4 & gate4, flags1 & gate1, flags0 & gate0}; // R4

  // Sources without a level field here run at a fixed mid level
  always_comb begin
    for (int i = 0; i < icp_pkg::NUM_SRC; i++) begin
      lvl[i*icp_pkg::LVL_W +: icp_pkg::LVL_W] = icp_pkg::LEVEL_FIXED;
    end
    lvl[icp_pkg::SRC_TIMER1*3 +: 3] = level0[icp_pkg::FLD_HI   +: 3]; // R11
    lvl[icp_pkg::SRC_CMP1*3   +: 3] = level0[icp_pkg::FLD_MID  +: 3];
    lvl[icp_pkg::SRC_CAP1*3   +: 3] = level0[icp_pkg::FLD_LO   +: 3];
    lvl[icp_pkg::SRC_EXT0*3   +: 3] = level0[icp_pkg::FLD_BASE +: 3];
    lvl[icp_pkg::SRC_TIMER2*3 +: 3] = level1[icp_pkg::FLD_HI   +: 3]; // R12
    lvl[icp_pkg::SRC_CMP2*3   +: 3] = level1[icp_pkg::FLD_MID  +: 3];
    lvl[icp_pkg::SRC_CAP2*3   +: 3] = level1[icp_pkg::FLD_LO   +: 3];
  end

  // Strict greater-than against an initial zero drops level 000 sources
  icp_level_arb #(.N(48), .LW(3), .IDW(6)) u_arb (
    .req       (live),
    .lvl       (lvl), // R8
    .win_valid (win_valid), // R9
    .win_level (win_level),
    .win_id    (win_id)
  );

  // ****************************************************************
  // Events and read data
  // ****************************************************************
  logic        core_req_q;
  logic [2:0]  core_level_q;
  logic [5:0]  core_src_q;
  logic        irq_q;
  logic        any_evt;
  logic [31:0] rd_word;

  assign any_evt = |(evt_group0 & icp_pkg::IMPL_GRP0) | |(evt_group1 & icp_pkg::IMPL_GRP1)
                 | |(evt_group4 & icp_pkg::IMPL_GRP4);
  assign irq_set = {win_valid & ~core_req_q, any_evt};

  assign rd_word = sel_flags0 ? {16'h0000, flags0} :
                   sel_flags1 ? {16'h0000, flags1} :
                   sel_flags4 ? {16'h0000, flags4} :
                   sel_gate0  ? {16'h0000, gate0}  :
                   sel_gate1  ? {16'h0000, gate1}  :
                   sel_gate4  ? {16'h0000, gate4}  :
                   sel_level0 ? {16'h0000, level0} :
                   sel_level1 ? {16'h0000, level1} :
                   sel_irq_st ? {30'h0000_0000, irq_st} :
                   sel_irq_mk ? {30'h0000_0000, irq_mk} :
                   sel_core   ? {22'h00_0000, core_src_q, core_level_q, core_req_q} :
                   32'h0000_0000; // R3

  // ****************************************************************
  // Output flops
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else if (clk_en) begin
      pready_q  <= setup;
      pslverr_q <= setup & ~mapped;
      if (setup) begin
        prdata_q <= rd_word;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_req_q   <= 1'b0;
      core_level_q <= 3'h0;
      core_src_q   <= 6'h00;
      irq_q        <= 1'b0;
    end else if (clk_en) begin
      core_req_q   <= win_valid; // R14
      core_level_q <= win_level;
      core_src_q   <= win_id;
      irq_q        <= |(irq_st & irq_mk);
    end
  end

  assign prdata     = prdata_q;
  assign pready     = pready_q;
  assign pslverr    = pslverr_q;
  assign core_req   = core_req_q;
  assign core_level = core_level_q;
  assign core_src   = core_src_q;
  assign irq        = irq_q;

endmodule // icp_regs
